// ===== core/frl_read_cfg.sv
// Read-latency selection and extended read register of a serial NOR flash.
// Assumes a command front end on the host serial clock that hands over each
// complete opcode (with its data byte for register writes) as a one-cycle strobe.
//
// Contract
// - Dummy clock count comes from read register bits 6 down to 3.
// - Zero field gives per-command default; N from 1 to 15 gives N dummies.
// - Single, single DTR, unique-ID, info-row reads: 8 dummies SPI, 6 QPI.
// - Dual and quad output reads default to 8 and are SPI only.
// - Dual-I/O read and its DTR variant default to 4, SPI only.
// - Quad-I/O read and its DTR variant default to 6 in SPI and QPI.
// - Dual-I/O DTR read is refused in QPI mode.
// - Extended register: drive strength 7..5, pattern enable 4, flags 3..0.
// - Extended register resets to drive bits one, all others zero.
// - Status bits 3..0 read-only; set commands leave them unchanged.
// - Opcode 85h writes the persistent copy, 83h the volatile copy.
// - Bit 0 mirrors the internal busy state.
// - Protection flag set when program or erase hits protected target.
// - Program flag set on program failure or protection error.
// - Erase flag set on erase failure or protection error.
// - Bit 4 is writable learning-pattern enable for DTR reads.
// - Power-up loads volatile registers from persistent copies.
// - Error flags stay set until clear command or resets; commands run.
// - Drive code map given; codes 000 and 100 are reserved.
`timescale 1ns/100ps
`default_nettype none
module frl_read_cfg #(
  parameter logic [7:0] UID_RD_OP = 8'h4B,
  parameter logic [7:0] INFO_RD_OP = 8'h68,
  parameter logic [7:0] CLR_FLAGS_OP = 8'h82
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic busy_in,
  input wire logic prog_fail,
  input wire logic prog_prot,
  input wire logic erase_fail,
  input wire logic erase_prot,
  input wire logic sw_reset,
  input wire logic [7:0] nv_read_in,
  input wire logic [7:0] nv_ext_in,
  output logic [7:0] read_reg_r,
  output logic [7:0] ext_reg_r,
  output logic [2:0] drive_strength_r,
  output logic drive_rsvd_r,
  output logic learning_pattern_en_r,
  output logic nv_wr_read_r,
  output logic nv_wr_ext_r,
  output logic [7:0] nv_wr_data_r,
  input wire logic link_clk,
  input wire logic qpi_mode,
  input wire logic link_cmd_stb,
  input wire logic [7:0] link_cmd_code,
  input wire logic [7:0] link_data,
  output logic [3:0] dummy_count_r,
  output logic cmd_accept_r,
  output logic cmd_reject_r,
  output logic [7:0] link_read_reg_r,
  output logic [7:0] link_ext_reg_r
);

  // Returns {legal, dummy count} for a read opcode; legal low for others
  function automatic logic [4:0] dummy_for(input logic [7:0] op, input logic qpi,
                                           input logic [3:0] field);
    logic [3:0] dflt;
    logic ok;
    dflt = frl_pkg::DUMMY_EIGHT;
    ok = 1'b0;
    if (op == frl_pkg::OP_FAST_RD_A || op == frl_pkg::OP_FAST_RD_B ||
        op == frl_pkg::OP_DTR_RD_A || op == frl_pkg::OP_DTR_RD_B ||
        op == UID_RD_OP || op == INFO_RD_OP)
    begin
      ok = 1'b1;
      dflt = qpi ? frl_pkg::DUMMY_SIX : frl_pkg::DUMMY_EIGHT;
    end
    else if (op == frl_pkg::OP_DUAL_OUT_A || op == frl_pkg::OP_DUAL_OUT_B ||
             op == frl_pkg::OP_QUAD_OUT_A || op == frl_pkg::OP_QUAD_OUT_B)
    begin
      ok = !qpi;
      dflt = frl_pkg::DUMMY_EIGHT;
    end
    else if (op == frl_pkg::OP_DUAL_IO_A || op == frl_pkg::OP_DUAL_IO_B ||
             op == frl_pkg::OP_DUAL_DTR_A || op == frl_pkg::OP_DUAL_DTR_B)
    begin
      ok = !qpi;
      dflt = frl_pkg::DUMMY_FOUR;
    end
    else if (op == frl_pkg::OP_QUAD_IO_A || op == frl_pkg::OP_QUAD_IO_B ||
             op == frl_pkg::OP_QUAD_DTR_A || op == frl_pkg::OP_QUAD_DTR_B)
    begin
      ok = 1'b1;
      dflt = frl_pkg::DUMMY_SIX;
    end
    // Nonzero field overrides every default
    if (field != frl_pkg::DUMMY_USE_DEFAULT)
      dflt = field;
    return {ok, dflt};
  endfunction : dummy_for

  // True for opcodes that carry a register write or flag clear
  function automatic logic is_reg_cmd(input logic [7:0] op);
    return op == frl_pkg::OP_SET_EXT_NV || op == frl_pkg::OP_SET_EXT_V ||
           op == frl_pkg::OP_SET_RD_NV || op == frl_pkg::OP_SET_RD_V_A ||
           op == frl_pkg::OP_SET_RD_V_B || op == CLR_FLAGS_OP;
  endfunction : is_reg_cmd

  // Link-domain state
  logic qpi_s1_r;
  logic qpi_s2_r;
  logic [7:0] xfer_code_r;
  logic [7:0] xfer_data_r;
  logic cmd_tgl_r;
  logic snap_s1_r;
  logic snap_s2_r;
  logic snap_s3_r;
  logic [4:0] rd_sel;
  // Core-domain state
  logic cmd_s1_r;
  logic cmd_s2_r;
  logic cmd_s3_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic snap_tgl_r;
  logic [15:0] snap_word_r;
  logic load_pend_r;
  logic cmd_evt;
  logic [7:0] ext_nxt;

  // Mode pin synchroniser into the link domain
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      qpi_s1_r <= 1'b0;
      qpi_s2_r <= 1'b0;
    end
    else
    begin
      qpi_s1_r <= qpi_mode;
      qpi_s2_r <= qpi_s1_r;
    end
  end

  // Read legality and count from the link-side register copy
  assign rd_sel = dummy_for(link_cmd_code, qpi_s2_r,
                            link_read_reg_r[frl_pkg::DUMMY_MSB:frl_pkg::DUMMY_LSB]);

  // Read start: count latched once per command, held for the whole read
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dummy_count_r <= frl_pkg::DUMMY_EIGHT;
      cmd_accept_r <= 1'b0;
      cmd_reject_r <= 1'b0;
    end
    else
    begin
      cmd_accept_r <= link_cmd_stb && rd_sel[4];
      cmd_reject_r <= link_cmd_stb && !rd_sel[4] && !is_reg_cmd(link_cmd_code);
      if (link_cmd_stb && rd_sel[4])
      begin
        dummy_count_r <= rd_sel[3:0];
      end
    end
  end

  // Register commands: held word plus toggle toward the core domain
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xfer_code_r <= 8'h00;
      xfer_data_r <= 8'h00;
      cmd_tgl_r <= 1'b0;
    end
    else if (link_cmd_stb && is_reg_cmd(link_cmd_code))
    begin
      xfer_code_r <= link_cmd_code;
      xfer_data_r <= link_data;
      cmd_tgl_r <= !cmd_tgl_r;
    end
  end

  // Snapshot toggle synchroniser into the link domain
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      snap_s1_r <= 1'b0;
      snap_s2_r <= 1'b0;
      snap_s3_r <= 1'b0;
    end
    else
    begin
      snap_s1_r <= snap_tgl_r;
      snap_s2_r <= snap_s1_r;
      snap_s3_r <= snap_s2_r;
    end
  end

  // Link copy of both registers, taken while the snapshot word is stable
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_read_reg_r <= frl_pkg::READ_RESET;
      link_ext_reg_r <= frl_pkg::EXT_RESET;
    end
    else if (snap_s2_r != snap_s3_r)
    begin
      link_read_reg_r <= snap_word_r[15:8];
      link_ext_reg_r <= snap_word_r[7:0];
    end
  end

  // Command toggle and snapshot acknowledge synchronisers into the core
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_s1_r <= 1'b0;
      cmd_s2_r <= 1'b0;
      cmd_s3_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      cmd_s1_r <= cmd_tgl_r;
      cmd_s2_r <= cmd_s1_r;
      cmd_s3_r <= cmd_s2_r;
      ack_s1_r <= snap_s3_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  assign cmd_evt = cmd_s2_r != cmd_s3_r;

  // Power-up load pending until the first enabled cycle after reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      load_pend_r <= 1'b1;
    else if (clk_en)
      load_pend_r <= 1'b0;
  end

  // Volatile read register: loaded at power-up, written by set commands
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      read_reg_r <= frl_pkg::READ_RESET;
    end
    else if (clk_en)
    begin
      if (load_pend_r)
      begin
        read_reg_r <= nv_read_in;
      end
      else if (cmd_evt && (xfer_code_r == frl_pkg::OP_SET_RD_V_A ||
                           xfer_code_r == frl_pkg::OP_SET_RD_V_B))
      begin
        read_reg_r <= xfer_data_r;
      end
    end
  end

  // Next extended image: writable bits, sticky flags, live busy bit
  always_comb
  begin
    ext_nxt = ext_reg_r;
    if (load_pend_r)
    begin
      ext_nxt = (nv_ext_in & frl_pkg::EXT_WR_MASK) | (ext_reg_r & ~frl_pkg::EXT_WR_MASK);
    end
    else if (cmd_evt && xfer_code_r == frl_pkg::OP_SET_EXT_V)
    begin
      ext_nxt = (xfer_data_r & frl_pkg::EXT_WR_MASK) | (ext_reg_r & ~frl_pkg::EXT_WR_MASK);
    end
    // Clear first so that a same-cycle error still sets the flag
    if (sw_reset || (cmd_evt && xfer_code_r == CLR_FLAGS_OP))
    begin
      ext_nxt[frl_pkg::EXT_ERASE_ERR] = 1'b0;
      ext_nxt[frl_pkg::EXT_PROG_ERR] = 1'b0;
      ext_nxt[frl_pkg::EXT_PROT_ERR] = 1'b0;
    end
    if (prog_prot || erase_prot)
    begin
      ext_nxt[frl_pkg::EXT_PROT_ERR] = 1'b1;
    end
    if (prog_fail || prog_prot)
    begin
      ext_nxt[frl_pkg::EXT_PROG_ERR] = 1'b1;
    end
    if (erase_fail || erase_prot)
    begin
      ext_nxt[frl_pkg::EXT_ERASE_ERR] = 1'b1;
    end
    ext_nxt[frl_pkg::EXT_BUSY] = busy_in;
  end

  // Extended register and its decoded fields
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_reg_r <= frl_pkg::EXT_RESET;
      drive_strength_r <= frl_pkg::EXT_RESET[frl_pkg::EXT_DS_MSB:frl_pkg::EXT_DS_LSB];
      drive_rsvd_r <= 1'b0;
      learning_pattern_en_r <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_reg_r <= ext_nxt;
      drive_strength_r <= ext_nxt[frl_pkg::EXT_DS_MSB:frl_pkg::EXT_DS_LSB];
      drive_rsvd_r <= ext_nxt[frl_pkg::EXT_DS_MSB:frl_pkg::EXT_DS_LSB] == frl_pkg::DS_RSVD_A ||
                      ext_nxt[frl_pkg::EXT_DS_MSB:frl_pkg::EXT_DS_LSB] == frl_pkg::DS_RSVD_B;
      learning_pattern_en_r <= ext_nxt[frl_pkg::EXT_LP_EN];
    end
  end

  // Persistent copy writes go out as one-cycle strobes with data
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nv_wr_read_r <= 1'b0;
      nv_wr_ext_r <= 1'b0;
      nv_wr_data_r <= 8'h00;
    end
    else if (clk_en)
    begin
      nv_wr_read_r <= cmd_evt && xfer_code_r == frl_pkg::OP_SET_RD_NV;
      nv_wr_ext_r <= cmd_evt && xfer_code_r == frl_pkg::OP_SET_EXT_NV;
      if (cmd_evt && xfer_code_r == frl_pkg::OP_SET_EXT_NV)
      begin
        nv_wr_data_r <= xfer_data_r & frl_pkg::EXT_WR_MASK;
      end
      else if (cmd_evt && xfer_code_r == frl_pkg::OP_SET_RD_NV)
      begin
        nv_wr_data_r <= xfer_data_r;
      end
    end
  end

  // Snapshot sender: new word only after the previous one was taken
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      snap_tgl_r <= 1'b0;
      snap_word_r <= {frl_pkg::READ_RESET, frl_pkg::EXT_RESET};
    end
    else if (clk_en && ack_s2_r == snap_tgl_r && snap_word_r != {read_reg_r, ext_reg_r})
    begin
      snap_word_r <= {read_reg_r, ext_reg_r};
      snap_tgl_r <= !snap_tgl_r;
    end
  end
endmodule : frl_read_cfg
`default_nettype wire

// ===== core/frl_pkg.sv
// Constants for the flash read-latency and extended read configuration block.
// Assumes one 8-bit opcode per command and 8-bit register images.
`default_nettype none
package frl_pkg;
  // Opcodes of the fast-read family
  localparam logic [7:0] OP_FAST_RD_A = 8'h0B;
  localparam logic [7:0] OP_FAST_RD_B = 8'h0C;
  localparam logic [7:0] OP_DTR_RD_A = 8'h0D;
  localparam logic [7:0] OP_DTR_RD_B = 8'h0E;
  localparam logic [7:0] OP_DUAL_OUT_A = 8'h3B;
  localparam logic [7:0] OP_DUAL_OUT_B = 8'h3C;
  localparam logic [7:0] OP_QUAD_OUT_A = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUT_B = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO_A = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_B = 8'hBC;
  localparam logic [7:0] OP_DUAL_DTR_A = 8'hBD;
  localparam logic [7:0] OP_DUAL_DTR_B = 8'hBE;
  localparam logic [7:0] OP_QUAD_IO_A = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_B = 8'hEC;
  localparam logic [7:0] OP_QUAD_DTR_A = 8'hED;
  localparam logic [7:0] OP_QUAD_DTR_B = 8'hEE;
  // Register-setting opcodes
  localparam logic [7:0] OP_SET_EXT_NV = 8'h85;
  localparam logic [7:0] OP_SET_EXT_V = 8'h83;
  localparam logic [7:0] OP_SET_RD_NV = 8'h65;
  localparam logic [7:0] OP_SET_RD_V_A = 8'hC0;
  localparam logic [7:0] OP_SET_RD_V_B = 8'h63;
  // Default dummy counts
  localparam logic [3:0] DUMMY_EIGHT = 4'h8;
  localparam logic [3:0] DUMMY_SIX = 4'h6;
  localparam logic [3:0] DUMMY_FOUR = 4'h4;
  localparam logic [3:0] DUMMY_USE_DEFAULT = 4'h0;
  // Read register dummy field
  localparam int DUMMY_MSB = 6;
  localparam int DUMMY_LSB = 3;
  // Extended register layout
  localparam int EXT_DS_MSB = 7;
  localparam int EXT_DS_LSB = 5;
  localparam int EXT_LP_EN = 4;
  localparam int EXT_ERASE_ERR = 3;
  localparam int EXT_PROG_ERR = 2;
  localparam int EXT_PROT_ERR = 1;
  localparam int EXT_BUSY = 0;
  localparam logic [7:0] EXT_WR_MASK = 8'hF0;
  localparam logic [7:0] EXT_RESET = 8'hE0;
  localparam logic [7:0] READ_RESET = 8'h00;
  // Drive strength codes with no defined strength
  localparam logic [2:0] DS_RSVD_A = 3'h0;
  localparam logic [2:0] DS_RSVD_B = 3'h4;
endpackage : frl_pkg
`default_nettype wire

// ===== tb/frl_read_cfg_monitor.sv
// Port checker for frl_read_cfg, both clock domains.
// Assumes it is bound onto every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module frl_read_cfg_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic busy_in,
  input wire logic prog_prot,
  input wire logic erase_fail,
  input wire logic erase_prot,
  input wire logic [7:0] ext_reg_r,
  input wire logic [2:0] drive_strength_r,
  input wire logic drive_rsvd_r,
  input wire logic learning_pattern_en_r,
  input wire logic link_clk,
  input wire logic qpi_mode,
  input wire logic link_cmd_stb,
  input wire logic [7:0] link_cmd_code,
  input wire logic [7:0] link_read_reg_r,
  input wire logic [3:0] dummy_count_r,
  input wire logic cmd_accept_r,
  input wire logic cmd_reject_r
);
  // Mode held long enough to pass the link synchroniser
  sequence s_spi3;
    !qpi_mode [*3];
  endsequence
  sequence s_qpi3;
    qpi_mode [*3];
  endsequence
  // Core-domain flag and field relations
  a_busy_mirror: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en |=> ext_reg_r[0] == $past(busy_in)) else $error("busy bit wrong");
  a_prot_flags: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && prog_prot |=> ext_reg_r[2:1] == 2'h3) else $error("prot flags not set");
  a_erase_flag: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && (erase_fail || erase_prot) |=> ext_reg_r[3]) else $error("erase flag not set");
  a_drive_view: assert property (@(posedge clk) disable iff (!rst_b)
    ext_reg_r[7:5] == drive_strength_r && ext_reg_r[4] == learning_pattern_en_r)
    else $error("field outputs disagree");
  a_rsvd_code: assert property (@(posedge clk) disable iff (!rst_b)
    drive_rsvd_r == (drive_strength_r == 3'h0 || drive_strength_r == 3'h4))
    else $error("reserved code flag wrong");
  // Link-domain read handling
  a_dtr_refused: assert property (@(posedge link_clk) disable iff (!rst_b)
    s_qpi3 ##0 (link_cmd_stb && link_cmd_code inside {8'hBD, 8'hBE})
    |=> cmd_reject_r && !cmd_accept_r) else $error("dual DTR taken in QPI");
  a_quad_io_count: assert property (@(posedge link_clk) disable iff (!rst_b)
    link_cmd_stb && link_cmd_code == 8'hEB |=> cmd_accept_r && dummy_count_r ==
    ($past(link_read_reg_r[6:3]) != 4'h0 ? $past(link_read_reg_r[6:3]) : 4'h6))
    else $error("quad IO dummy count wrong");
  a_dual_io_count: assert property (@(posedge link_clk) disable iff (!rst_b)
    s_spi3 ##0 (link_cmd_stb && link_cmd_code == 8'hBB && link_read_reg_r[6:3] == 4'h0)
    |=> cmd_accept_r && dummy_count_r == 4'h4) else $error("dual IO default wrong");
endmodule : frl_read_cfg_monitor
bind frl_read_cfg frl_read_cfg_monitor i_mon (.*);
`default_nettype wire

// ===== tb/frl_host_model.sv
// Host serial controller model on the link side of frl_read_cfg.
// Assumes the bench calls run(); the link clock stays low between frames.
`timescale 1ns/100ps
`default_nettype none
module frl_host_model (
  output logic link_clk,
  output logic link_cmd_stb,
  output logic [7:0] link_cmd_code,
  output logic [7:0] link_data,
  input wire logic cmd_accept_r,
  input wire logic cmd_reject_r,
  input wire logic [3:0] dummy_count_r
);
  logic got_acc;
  logic got_rej;
  logic [3:0] got_dummy;
  // Parked levels
  initial
  begin
    link_clk = 1'b0;
    link_cmd_stb = 1'b0;
    link_cmd_code = 8'h00;
    link_data = 8'h00;
  end
  // Frame of n cycles; strobe taken on the fourth rise, answer caught after it
  task automatic run(input logic [7:0] c, input logic [7:0] d, input logic s, input int n);
    for (int i = 0; i < n; i++)
    begin
      #16 link_clk = 1'b1;
      #1 link_cmd_stb = s && i == 2;
      link_cmd_code = (i == 2) ? c : ~link_cmd_code;
      link_data = (i == 2) ? d : ~link_data;
      got_acc = (i == 3) ? cmd_accept_r : got_acc;
      got_rej = (i == 3) ? cmd_reject_r : got_rej;
      got_dummy = (i == 3) ? dummy_count_r : got_dummy;
      #15 link_clk = 1'b0;
    end
  endtask : run
endmodule : frl_host_model
`default_nettype wire

// ===== tb/frl_read_cfg_bench.sv
// Self-checking bench for frl_read_cfg.
// Assumes frl_host_model drives the link side.
`timescale 1ns/100ps
`default_nettype none
// Compare and count
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module frl_read_cfg_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic busy_in = 1'b0;
  logic qpi_mode = 1'b0;
  logic [4:0] evt = 5'h00;
  logic [7:0] nv_read_in = 8'h81;
  logic [7:0] nv_ext_in = 8'h9F;
  logic link_clk, link_cmd_stb, drive_rsvd_r, learning_pattern_en_r;
  logic nv_wr_read_r, nv_wr_ext_r, cmd_accept_r, cmd_reject_r;
  logic [7:0] link_cmd_code, link_data, read_reg_r, ext_reg_r, nv_wr_data_r;
  logic [7:0] link_read_reg_r, link_ext_reg_r;
  logic [2:0] drive_strength_r;
  logic [3:0] dummy_count_r;
  int err_total = 0;
  int num_checks = 0;
  int nv_cnt = 0;
  int nv_rd_cnt = 0;
  // Opcode, SPI count, QPI count (0 means refused)
  logic [15:0] tbl [18] = '{16'h0B86, 16'h0C86, 16'h0D86, 16'h0E86, 16'h3B80, 16'h3C80,
    16'h6B80, 16'h6C80, 16'hBB40, 16'hBC40, 16'hBD40, 16'hBE40, 16'hEB66, 16'hEC66,
    16'hED66, 16'hEE66, 16'h4B86, 16'h6886};
  always #2.5 clk = ~clk;
  // Persistent write pulses seen
  always @(posedge clk) if (nv_wr_ext_r === 1'b1) nv_cnt++;
  always @(posedge clk) if (nv_wr_read_r === 1'b1) nv_rd_cnt++;
  frl_read_cfg i_dut (.*, .prog_fail(evt[4]), .prog_prot(evt[3]), .erase_fail(evt[2]),
    .erase_prot(evt[1]), .sw_reset(evt[0]));
  frl_host_model i_host (.*);
  // One-cycle core event
  task automatic pulse(input int b);
    @(posedge clk);
    #1 evt[b] = 1'b1;
    @(posedge clk);
    #1 evt[b] = 1'b0;
  endtask : pulse
  // Read command; answer compared with expected count
  task automatic rd(input logic [7:0] op, input logic [3:0] e);
    i_host.run(op, 8'h00, 1'b1, 11);
    if (e == 4'h0) `CHK({i_host.got_acc, i_host.got_rej}, 2'b01)
    else `CHK({i_host.got_acc, i_host.got_rej, i_host.got_dummy}, {2'b10, e})
  endtask : rd
  // Register command
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    i_host.run(op, d, 1'b1, 11);
  endtask : wr
  // Reset with both clocks ticking
  task automatic do_reset;
    rst_b = 1'b0;
    fork
      repeat (4) @(posedge clk);
      i_host.run(8'h00, 8'h00, 1'b0, 3);
    join
    `CHK(ext_reg_r, frl_pkg::EXT_RESET)
    `CHK(dummy_count_r, frl_pkg::DUMMY_EIGHT)
    @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 10 && ext_reg_r[7:4] !== 4'h9; i++) @(posedge clk);
    `CHK(read_reg_r, 8'h81)
    `CHK(ext_reg_r, 8'h90)
  endtask : do_reset
  // Verdict
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial
  begin
    do_reset();
    `CHK(drive_rsvd_r, 1'b1)
    for (int m = 0; m < 2; m++)
    begin
      qpi_mode = m[0];
      for (int k = 0; k < 18; k++)
        rd(tbl[k][15:8], m ? tbl[k][3:0] : tbl[k][7:4]);
    end
    qpi_mode = 1'b0;
    wr(frl_pkg::OP_SET_RD_V_A, 8'h28);
    `CHK(read_reg_r, 8'h28)
    rd(frl_pkg::OP_DUAL_OUT_A, 4'h5);
    wr(frl_pkg::OP_SET_RD_V_B, 8'h78);
    rd(frl_pkg::OP_DUAL_DTR_A, 4'hF);
    `CHK(link_read_reg_r, 8'h78)
    // Persistent read register write leaves the volatile copy alone
    wr(frl_pkg::OP_SET_RD_NV, 8'h5A);
    `CHK(nv_wr_data_r, 8'h5A)
    `CHK(nv_rd_cnt, 1)
    `CHK(read_reg_r, 8'h78)
    pulse(3);
    `CHK(ext_reg_r[3:0], 4'h6)
    wr(frl_pkg::OP_SET_EXT_V, 8'h1F);
    `CHK(ext_reg_r, 8'h16)
    `CHK(learning_pattern_en_r, 1'b1)
    `CHK(drive_strength_r, 3'h0)
    `CHK(link_ext_reg_r[7:4], 4'h1)
    rd(frl_pkg::OP_FAST_RD_A, 4'hF);
    wr(frl_pkg::OP_SET_EXT_NV, 8'hBF);
    `CHK(nv_wr_data_r, 8'hB0)
    `CHK(nv_cnt, 1)
    // Legal drive code, pattern off, sticky flags kept
    wr(frl_pkg::OP_SET_EXT_V, 8'hE5);
    `CHK(drive_strength_r, 3'h7)
    `CHK(drive_rsvd_r, 1'b0)
    `CHK(learning_pattern_en_r, 1'b0)
    `CHK(ext_reg_r, 8'hE6)
    wr(8'h82, 8'h00);
    `CHK(ext_reg_r[3:1], 3'h0)
    pulse(2);
    `CHK(ext_reg_r[3:1], 3'h4)
    pulse(4);
    `CHK(ext_reg_r[3:1], 3'h6)
    pulse(0);
    `CHK(ext_reg_r[3:1], 3'h0)
    pulse(1);
    `CHK(ext_reg_r[3:1], 3'h5)
    @(posedge clk);
    #1 busy_in = 1'b1;
    @(posedge clk);
    #1 `CHK(ext_reg_r[0], 1'b1)
    clk_en = 1'b0;
    busy_in = 1'b0;
    @(posedge clk);
    #1 `CHK(ext_reg_r[0], 1'b1)
    clk_en = 1'b1;
    @(posedge clk);
    #1 `CHK(ext_reg_r[0], 1'b0)
    do_reset();
    end_of_test();
  end
endmodule : frl_read_cfg_bench
`default_nettype wire
